// ---- verilog/port_mux_pkg.sv ----
// constants for the two-port gpio and pin multiplexer
package port_mux_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int          ADDR_W     = 12;
	localparam int          DATA_W     = 32;
	localparam int          PORT_W     = 8;
	localparam int          SEG_COUNT  = 24;

	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [9:0]  IDX_THIRD_PINS  = 10'h007;
	localparam logic [9:0]  IDX_FOURTH_PINS = 10'h008;
	localparam logic [9:0]  IDX_THIRD_DIR   = 10'h087;
	localparam logic [9:0]  IDX_FOURTH_DIR  = 10'h088;
	localparam logic [9:0]  IDX_SEG_LOW     = 10'h11C;
	localparam logic [9:0]  IDX_SEG_MID     = 10'h11D;
	localparam logic [9:0]  IDX_SEG_HIGH    = 10'h11E;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  DIR_RESET   = 8'hFF;
	localparam logic [7:0]  LATCH_RESET = 8'h00;
	localparam logic [7:0]  SEG_RESET   = 8'h00;

	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam logic [7:0]  OSC_DIR_MASK = 8'hC0;
	localparam int          PIN_TIMER_CLK = 5;
	localparam int          PIN_CCP_ONE   = 5;
	localparam int          PIN_SER_CLK   = 6;
	localparam int          PIN_SER_DATA  = 7;
	localparam int          PIN_CCP_TWO   = 2;
	localparam int          PIN_COM_THREE = 0;

	// ------------------------------------------------------------
	// segment ownership per pin
	// ------------------------------------------------------------
	localparam logic [7:0]  THIRD_SEG_MASK  = 8'hF8;
	localparam logic [4:0]  THIRD_SEG_NUM [0:7] = '{5'h00, 5'h00, 5'h00, 5'h06,
	                                                5'h0B, 5'h0A, 5'h09, 5'h08};
	localparam logic [7:0]  FOURTH_SEG_MASK = 8'hF8;
	localparam logic [4:0]  FOURTH_SEG_NUM [0:7] = '{5'h00, 5'h00, 5'h00, 5'h10,
	                                                 5'h11, 5'h12, 5'h13, 5'h14};

endpackage

// ---- verilog/dual_port_gpio_pin_mux.sv ----
// two 8-bit gpio ports with peripheral and lcd pin multiplexing, apb slave
// Contract
// RULE1 - fourth port has eight pins, each direction set on its own
// RULE2 - direction one tri-states the pin, zero enables its driver
// RULE3 - in crystal, high-speed, low-power osc modes direction bits 7:6 read one
// RULE4 - fourth direction at index 0x88, all ones on every reset
// RULE5 - reading fourth data register returns sensed pin levels
// RULE6 - fourth port and its direction exist only on large package
// RULE7 - lcd owning a pin drives or tri-states it, overriding port logic
// RULE8 - third pin 5: gpio, timer clock in, capture unit one, segment 10
// RULE9 - third pin 6: gpio, serial transmit or clock, spi or i2c clock, segment 9
// RULE10 - third pin 7: gpio, serial receive or data, spi or i2c data, segment 8
// RULE11 - fourth pin 2: gpio or capture unit two
// RULE12 - fourth pins 3-7 gpio or segments 16-20; pin 1 gpio only
// RULE13 - segment enables clear only on power-on or brown-out reset
// RULE14 - third data register at index 0x07, untouched by other resets
// RULE15 - unimplemented bits read as zero
// RULE16 - data write updates latch, driven only when direction is output
// RULE17 - enabled peripheral overrides latch and direction on its pin
`timescale 1ns/1ps
`default_nettype none

module dual_port_gpio_pin_mux
	import port_mux_pkg::*;
#(
	parameter bit LARGE_PACKAGE = 1'b1
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  other_reset,
	input  wire logic                  osc_pin_mode,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [DATA_W-1:0]     pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [DATA_W-1:0]     prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [PORT_W-1:0]     third_port_in,
	output logic      [PORT_W-1:0]     third_port_out,
	output logic      [PORT_W-1:0]     third_port_oe_n,
	input  wire logic [PORT_W-1:0]     fourth_port_in,
	output logic      [PORT_W-1:0]     fourth_port_out,
	output logic      [PORT_W-1:0]     fourth_port_oe_n,
	output logic                       timer_external_clock_in,
	input  wire logic                  ccp_one_en,
	input  wire logic                  ccp_one_out,
	input  wire logic                  ccp_one_oe_n,
	output logic                       ccp_one_in,
	input  wire logic                  ser_clk_en,
	input  wire logic                  ser_clk_out,
	input  wire logic                  ser_clk_oe_n,
	output logic                       ser_clk_in,
	input  wire logic                  ser_data_en,
	input  wire logic                  ser_data_out,
	input  wire logic                  ser_data_oe_n,
	output logic                       ser_data_in,
	input  wire logic                  ccp_two_en,
	input  wire logic                  ccp_two_out,
	input  wire logic                  ccp_two_oe_n,
	output logic                       ccp_two_in,
	input  wire logic                  lcd_enable,
	input  wire logic [SEG_COUNT-1:0]  lcd_segment_output,
	input  wire logic [SEG_COUNT-1:0]  lcd_segment_oe_n,
	input  wire logic                  lcd_common_three_en,
	input  wire logic                  lcd_common_output_three,
	input  wire logic                  lcd_common_three_oe_n
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		logic [9:0] idx;
		idx = a[ADDR_W-1:2];
		reg_hit = 1'b0;
		if (a[1:0] == 2'b00) begin
			case (idx)
				IDX_THIRD_PINS, IDX_THIRD_DIR,
				IDX_SEG_LOW, IDX_SEG_MID:       reg_hit = 1'b1;
				IDX_FOURTH_PINS, IDX_FOURTH_DIR,
				IDX_SEG_HIGH:                   reg_hit = LARGE_PACKAGE;
				default:                        reg_hit = 1'b0;
			endcase
		end
	endfunction

	logic [PORT_W-1:0]   third_latch_r;
	logic [PORT_W-1:0]   fourth_latch_r;
	logic [PORT_W-1:0]   third_port_direction_r;
	logic [PORT_W-1:0]   fourth_port_direction_r;
	logic [PORT_W-1:0]   segment_enable_low_r;
	logic [PORT_W-1:0]   segment_enable_mid_r;
	logic [PORT_W-1:0]   segment_enable_high_r;
	logic [DATA_W-1:0]   prdata_r;
	logic [DATA_W-1:0]   prdata_nxt;
	logic [SEG_COUNT-1:0] seg_en;
	logic [9:0]          idx;
	logic                wr_en;
	logic                hit;
	logic [PORT_W-1:0]   osc_force;

	assign idx       = paddr[ADDR_W-1:2];
	assign hit       = reg_hit(paddr);
	assign wr_en     = psel & penable & pwrite & hit & pstrb[0];
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~hit;
	assign prdata    = prdata_r;
	assign seg_en    = {segment_enable_high_r, segment_enable_mid_r, segment_enable_low_r};
	assign osc_force = osc_pin_mode ? OSC_DIR_MASK : 8'h00;

	// ------------------------------------------------------------
	// data latches
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			third_latch_r <= LATCH_RESET;
		end else if (wr_en && idx == IDX_THIRD_PINS) begin
			third_latch_r <= pwdata[PORT_W-1:0]; // [RULE14] [RULE16]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fourth_latch_r <= LATCH_RESET;
		end else if (wr_en && idx == IDX_FOURTH_PINS && LARGE_PACKAGE) begin
			fourth_latch_r <= pwdata[PORT_W-1:0]; // [RULE16] [RULE6]
		end
	end

	// ------------------------------------------------------------
	// direction registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			third_port_direction_r <= DIR_RESET;
		end else if (other_reset) begin
			third_port_direction_r <= DIR_RESET;
		end else if (wr_en && idx == IDX_THIRD_DIR) begin
			third_port_direction_r <= pwdata[PORT_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fourth_port_direction_r <= DIR_RESET; // [RULE4]
		end else if (other_reset) begin
			fourth_port_direction_r <= DIR_RESET; // [RULE4]
		end else if (wr_en && idx == IDX_FOURTH_DIR && LARGE_PACKAGE) begin
			fourth_port_direction_r <= pwdata[PORT_W-1:0]; // [RULE1]
		end
	end

	// ------------------------------------------------------------
	// segment enables, cleared by power-on reset only
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			segment_enable_low_r  <= SEG_RESET; // [RULE13]
			segment_enable_mid_r  <= SEG_RESET;
			segment_enable_high_r <= SEG_RESET;
		end else if (wr_en) begin
			if (idx == IDX_SEG_LOW) begin
				segment_enable_low_r <= pwdata[PORT_W-1:0];
			end
			if (idx == IDX_SEG_MID) begin
				segment_enable_mid_r <= pwdata[PORT_W-1:0];
			end
			if (idx == IDX_SEG_HIGH && LARGE_PACKAGE) begin
				segment_enable_high_r <= pwdata[PORT_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// read path, captured in the setup cycle
	// ------------------------------------------------------------
	always_comb begin
		prdata_nxt = '0; // [RULE15]
		if (hit) begin
			case (idx)
				IDX_THIRD_PINS:  prdata_nxt[PORT_W-1:0] = third_port_in;
				IDX_FOURTH_PINS: prdata_nxt[PORT_W-1:0] = fourth_port_in; // [RULE5]
				IDX_THIRD_DIR:   prdata_nxt[PORT_W-1:0] = third_port_direction_r | osc_force;
				IDX_FOURTH_DIR:  prdata_nxt[PORT_W-1:0] = fourth_port_direction_r | osc_force; // [RULE3]
				IDX_SEG_LOW:     prdata_nxt[PORT_W-1:0] = segment_enable_low_r;
				IDX_SEG_MID:     prdata_nxt[PORT_W-1:0] = segment_enable_mid_r;
				IDX_SEG_HIGH:    prdata_nxt[PORT_W-1:0] = segment_enable_high_r;
				default:         prdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= prdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// third port pin multiplexer
	// ------------------------------------------------------------
	always_comb begin
		third_port_out  = third_latch_r; // [RULE16]
		third_port_oe_n = third_port_direction_r; // [RULE2]
		if (ccp_one_en) begin
			third_port_out[PIN_CCP_ONE]  = ccp_one_out; // [RULE8] [RULE17]
			third_port_oe_n[PIN_CCP_ONE] = ccp_one_oe_n;
		end
		if (ser_clk_en) begin
			third_port_out[PIN_SER_CLK]  = ser_clk_out; // [RULE9] [RULE17]
			third_port_oe_n[PIN_SER_CLK] = ser_clk_oe_n;
		end
		if (ser_data_en) begin
			third_port_out[PIN_SER_DATA]  = ser_data_out; // [RULE10] [RULE17]
			third_port_oe_n[PIN_SER_DATA] = ser_data_oe_n;
		end
		for (int i = 0; i < PORT_W; i++) begin
			if (THIRD_SEG_MASK[i] && lcd_enable && seg_en[THIRD_SEG_NUM[i]]) begin
				third_port_out[i]  = lcd_segment_output[THIRD_SEG_NUM[i]]; // [RULE7]
				third_port_oe_n[i] = lcd_segment_oe_n[THIRD_SEG_NUM[i]];
			end
		end
	end

	// ------------------------------------------------------------
	// fourth port pin multiplexer
	// ------------------------------------------------------------
	always_comb begin
		fourth_port_out  = fourth_latch_r;
		fourth_port_oe_n = fourth_port_direction_r; // [RULE1] [RULE2]
		if (ccp_two_en) begin
			fourth_port_out[PIN_CCP_TWO]  = ccp_two_out; // [RULE11] [RULE17]
			fourth_port_oe_n[PIN_CCP_TWO] = ccp_two_oe_n;
		end
		if (lcd_enable && lcd_common_three_en) begin
			fourth_port_out[PIN_COM_THREE]  = lcd_common_output_three; // [RULE7]
			fourth_port_oe_n[PIN_COM_THREE] = lcd_common_three_oe_n;
		end
		for (int i = 0; i < PORT_W; i++) begin
			if (FOURTH_SEG_MASK[i] && lcd_enable && seg_en[FOURTH_SEG_NUM[i]]) begin
				fourth_port_out[i]  = lcd_segment_output[FOURTH_SEG_NUM[i]]; // [RULE12] [RULE7]
				fourth_port_oe_n[i] = lcd_segment_oe_n[FOURTH_SEG_NUM[i]];
			end
		end
		if (!LARGE_PACKAGE) begin
			fourth_port_out  = '0; // [RULE6]
			fourth_port_oe_n = '1;
		end
	end

	// ------------------------------------------------------------
	// peripheral inputs taken from pins
	// ------------------------------------------------------------
	assign timer_external_clock_in = third_port_in[PIN_TIMER_CLK]; // [RULE8]
	assign ccp_one_in              = third_port_in[PIN_CCP_ONE];
	assign ser_clk_in              = third_port_in[PIN_SER_CLK]; // [RULE9]
	assign ser_data_in             = third_port_in[PIN_SER_DATA]; // [RULE10]
	assign ccp_two_in              = LARGE_PACKAGE ? fourth_port_in[PIN_CCP_TWO] : 1'b0; // [RULE11]

endmodule

`default_nettype wire

// ---- tb/port_mux_chk.sv ----
// concurrent checks on the gpio and pin multiplexer ports
`timescale 1ns/1ps
`default_nettype none
module port_mux_chk
	import port_mux_pkg::*;
(
	input wire logic			pclk,
	input wire logic			presetn,
	input wire logic			other_reset,
	input wire logic			osc_pin_mode,
	input wire logic			psel,
	input wire logic			penable,
	input wire logic			pwrite,
	input wire logic [ADDR_W-1:0]	paddr,
	input wire logic [DATA_W-1:0]	pwdata,
	input wire logic [3:0]		pstrb,
	input wire logic [DATA_W-1:0]	prdata,
	input wire logic			pslverr,
	input wire logic [PORT_W-1:0]	fourth_port_in,
	input wire logic [PORT_W-1:0]	fourth_port_out,
	input wire logic [PORT_W-1:0]	fourth_port_oe_n,
	input wire logic			ccp_two_en,
	input wire logic			ccp_two_out,
	input wire logic			ccp_two_oe_n,
	input wire logic			ccp_two_in
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence dir_wr; psel && penable && pwrite && pstrb[0] && paddr == 12'h220 && !other_reset; endsequence
	sequence rd_setup(a); psel && !penable && !pwrite && paddr == a ##1 psel && penable; endsequence
	dir_write_a: assert property (dir_wr |=> fourth_port_oe_n[1] == $past(pwdata[1]))
		else $error("direction write lost");
	other_reset_a: assert property (other_reset |=> fourth_port_oe_n[1]) else $error("direction not set");
	fourth_read_a: assert property (rd_setup(12'h020) |-> prdata == {24'h0, $past(fourth_port_in)})
		else $error("pin read wrong");
	osc_read_a: assert property (rd_setup(12'h220) |-> !$past(osc_pin_mode) || prdata[7:6] == 2'b11)
		else $error("osc bits wrong");
	err_map_a: assert property (psel && penable && !pwrite && paddr == 12'h004 |-> pslverr && prdata == '0)
		else $error("unmapped read wrong");
	map_ok_a: assert property (psel && penable && paddr == 12'h220 |-> !pslverr) else $error("mapped error");
	ccp_two_a: assert property (ccp_two_en |-> fourth_port_out[2] == ccp_two_out && fourth_port_oe_n[2] == ccp_two_oe_n)
		else $error("ccp two not routed");
	ccp_sense_a: assert property (ccp_two_in == fourth_port_in[2]) else $error("ccp two sense");
endmodule
bind dual_port_gpio_pin_mux port_mux_chk i_port_mux_chk (.*);
`default_nettype wire

// ---- tb/board_model.sv ----
// board model: sensed levels of one eight-pin port
`timescale 1ns/1ps
`default_nettype none
module board_model (
	input wire logic		pclk,
	input wire logic [7:0]	pin_out,
	input wire logic [7:0]	pin_oe_n,
	input wire logic [7:0]	ext_val,
	input wire logic [7:0]	ext_drv,
	output logic [7:0]	pin_lvl
);
	logic [7:0]	last_r = 8'h00;
	// device drive wins, then the board; a floating pin flips every cycle
	assign pin_lvl = (~pin_oe_n & pin_out) | (pin_oe_n & ext_drv & ext_val) | (pin_oe_n & ~ext_drv & ~last_r);
	always @(posedge pclk) last_r <= pin_lvl;
endmodule
`default_nettype wire

// ---- tb/dual_port_gpio_pin_mux_test.sv ----
// self-checking bench for the gpio and pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module dual_port_gpio_pin_mux_test;
	import port_mux_pkg::*;
	logic		pclk = 0, presetn = 0, other_reset = 0, osc_pin_mode = 0, psel = 0, penable = 0, pwrite = 0;
	logic		pready, pslverr, err, lcd_enable = 0, lcd_common_three_en = 0, lcd_common_output_three = 0;
	logic		lcd_common_three_oe_n = 1;
	logic [3:0]	pstrb = 4'hF, pe_en = 0, pe_out = 0, pe_oe = 0;
	logic [11:0]	paddr = 0;
	logic [31:0]	pwdata = 0, prdata, rd;
	logic [7:0]	third_port_in, third_port_out, third_port_oe_n, fourth_port_in, fourth_port_out, fourth_port_oe_n;
	logic [7:0]	d, v, ev = 0, ed = 0;
	logic [23:0]	lcd_segment_output = 0, lcd_segment_oe_n = 0;
	logic [4:0]	pin_sense;
	int		n_mismatch = 0, tests_run = 0;
	dual_port_gpio_pin_mux i_dual_port_gpio_pin_mux (.*, .timer_external_clock_in(pin_sense[4]),
		.ccp_one_in(pin_sense[3]), .ser_clk_in(pin_sense[2]), .ser_data_in(pin_sense[1]), .ccp_two_in(pin_sense[0]),
		.ccp_one_en(pe_en[0]), .ccp_one_out(pe_out[0]), .ccp_one_oe_n(pe_oe[0]),
		.ser_clk_en(pe_en[1]), .ser_clk_out(pe_out[1]), .ser_clk_oe_n(pe_oe[1]), .ser_data_en(pe_en[2]),
		.ser_data_out(pe_out[2]), .ser_data_oe_n(pe_oe[2]), .ccp_two_en(pe_en[3]), .ccp_two_out(pe_out[3]),
		.ccp_two_oe_n(pe_oe[3]));
	board_model third_board (.pclk, .pin_out(third_port_out), .pin_oe_n(third_port_oe_n), .ext_val(ev),
		.ext_drv(ed), .pin_lvl(third_port_in));
	board_model fourth_board (.pclk, .pin_out(fourth_port_out), .pin_oe_n(fourth_port_oe_n), .ext_val(ev),
		.ext_drv(ed), .pin_lvl(fourth_port_in));
	always #5 pclk = ~pclk;
	function automatic logic [7:0] lvl(logic [7:0] l, logic [7:0] dr, logic [7:0] e);
		return (l & ~dr) | (e & dr);
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#50us;
		n_mismatch++;
		results();
	end
	initial begin
		void'($urandom(99));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rc("dir reset", 12'h220, 32'hFF);
		rc("seg reset", 12'h478, 32'h0);
		chk("oe reset", 32'hFFFF, {fourth_port_oe_n, third_port_oe_n});
		ed <= 8'hFF;
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			v = 8'($urandom);
			ev <= 8'($urandom);
			apb(1'b1, 12'h220, {24'h0, d});
			apb(1'b1, 12'h020, {24'h0, v});
			apb(1'b1, 12'h01C, {24'h0, v});
			chk("fourth oe", d, fourth_port_oe_n);
			rc("fourth pins", 12'h020, lvl(v, d, ev));
		end
		apb(1'b0, 12'h004, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], err});
		apb(1'b1, 12'h222, {24'h0, ~d});
		rc("misaligned", 12'h220, d);
		pstrb <= 4'hE;
		apb(1'b1, 12'h220, {24'h0, ~d});
		pstrb <= 4'hF;
		rc("strobe off", 12'h220, d);
		$display("gpio test done");
		apb(1'b1, 12'h470, 32'h5A);
		osc_pin_mode <= 1'b1;
		other_reset <= 1'b1;
		@(posedge pclk);
		other_reset <= 1'b0;
		rc("dir other reset", 12'h220, 32'hFF);
		rc("seg kept", 12'h470, 32'h5A);
		apb(1'b1, 12'h220, 32'h0);
		apb(1'b1, 12'h21C, 32'h0);
		rc("osc dir", 12'h220, 32'hC0);
		chk("osc pins", 32'h0, fourth_port_oe_n);
		osc_pin_mode <= 1'b0;
		rc("latch kept", 12'h020, v);
		rc("third latch kept", 12'h01C, v);
		$display("reset source test done");
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk);
			pe_en <= 4'($urandom);
			pe_out <= 4'($urandom);
			pe_oe <= 4'($urandom);
			@(posedge pclk);
			#1;
			for (int k = 0; k < 3; k++)
				chk("third pin", pe_en[k] ? {pe_oe[k], pe_out[k]} : {1'b0, v[k+5]}, {third_port_oe_n[k+5], third_port_out[k+5]});
			chk("ccp two pin", pe_en[3] ? {pe_oe[3], pe_out[3]} : {1'b0, v[2]}, {fourth_port_oe_n[2], fourth_port_out[2]});
			chk("pin sense", {third_port_in[5], third_port_in[5], third_port_in[6], third_port_in[7], fourth_port_in[2]}, pin_sense);
		end
		$display("peripheral test done");
		@(posedge pclk);
		lcd_enable <= 1'b1;
		lcd_common_three_en <= 1'b1;
		lcd_common_output_three <= 1'($urandom);
		lcd_segment_output <= 24'($urandom);
		lcd_segment_oe_n <= 24'($urandom);
		pe_en <= 4'hF;
		apb(1'b1, 12'h478, 32'h1F);
		apb(1'b1, 12'h474, 32'h07);
		@(posedge pclk);
		#1;
		chk("fourth seg", {lcd_segment_oe_n[20:16], lcd_segment_output[20:16]}, {fourth_port_oe_n[7:3], fourth_port_out[7:3]});
		chk("third seg", {lcd_segment_output[8], lcd_segment_output[9], lcd_segment_output[10]}, third_port_out[7:5]);
		chk("common pin", {lcd_common_three_oe_n, lcd_common_output_three, 1'b0, v[1]},
			{fourth_port_oe_n[0], fourth_port_out[0], fourth_port_oe_n[1], fourth_port_out[1]});
		$display("lcd test done");
		results();
	end
endmodule
`default_nettype wire
